/* File: hdl/urx_fifo.v */
// Purpose: synchronous FIFO with valid and ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes: out_data shows the head word while out_valid is high
`timescale 1ns/1ps
`default_nettype none

module urx_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire ref_clk,
	input wire rst_b,
	input wire flush,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	output wire [AW:0] count
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
reg [AW:0] cnt;
wire push;
wire pop;

assign in_ready = (cnt != DEPTH[AW:0]);
assign out_valid = (cnt != {(AW+1){1'b0}});
assign push = in_valid & in_ready;
assign pop = out_ready & out_valid;
assign out_data = mem[rd_ptr];
assign count = cnt;

always @(posedge ref_clk)
begin
	if (push)
	begin
		mem[wr_ptr] <= in_data;
	end
end

always @(posedge ref_clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		wr_ptr <= {AW{1'b0}};
		rd_ptr <= {AW{1'b0}};
		cnt <= {(AW+1){1'b0}};
	end
	else if (flush)
	begin
		wr_ptr <= {AW{1'b0}};
		rd_ptr <= {AW{1'b0}};
		cnt <= {(AW+1){1'b0}};
	end
	else
	begin
		if (push)
			wr_ptr <= wr_ptr + 1'b1;
		if (pop)
			rd_ptr <= rd_ptr + 1'b1;
		if (push && !pop)
			cnt <= cnt + 1'b1;
		else if (pop && !push)
			cnt <= cnt - 1'b1;
	end
end

endmodule // urx_fifo

`default_nettype wire

/* File: hdl/urx_map.vh */
// Purpose: register offsets, field positions, reset values and timing counts of the receive block
// Assumes: 3-bit register address, 8-bit register data
// Notes: header only, definitions and nothing else
`ifndef URX_MAP_VH
`define URX_MAP_VH

// register offsets
`define URX_ADDR_RX_DATA 3'h0
`define URX_ADDR_INT_ENABLE 3'h1
`define URX_ADDR_FIFO_CONTROL 3'h2
`define URX_ADDR_MODEM_CONTROL 3'h4
`define URX_ADDR_LINE_STATUS 3'h5
`define URX_ADDR_MODEM_STATUS 3'h6

// reset values
`define URX_RST_INT_ENABLE 4'h0
`define URX_RST_FIFO_CONTROL 8'h00
`define URX_RST_MODEM_CONTROL 5'h00

// field positions
`define URX_IER_MODEM_BIT 3
`define URX_FCR_FIFO_EN_BIT 0
`define URX_FCR_RX_FLUSH_BIT 1
`define URX_FCR_DMA_SEL_BIT 3
`define URX_FCR_TRIG_HI 7
`define URX_FCR_TRIG_LO 6
`define URX_MCR_RTS_BIT 1
`define URX_MCR_OUT1_BIT 2
`define URX_MCR_LOOP_BIT 4
`define URX_MSR_RING_EDGE_BIT 2
`define URX_MSR_RING_LEVEL_BIT 6
`define URX_LSR_READY_BIT 0
`define URX_LSR_OVERRUN_BIT 1
`define URX_LSR_FRAMING_BIT 3

// receive FIFO trigger levels
`define URX_TRIG_LVL0 6'h01
`define URX_TRIG_LVL1 6'h04
`define URX_TRIG_LVL2 6'h08
`define URX_TRIG_LVL3 6'h0E

// receive FIFO shape
`define URX_FIFO_WIDTH 8
`define URX_FIFO_DEPTH 32
`define URX_FIFO_AW 5

// sampling: 16 ticks of the receive clock per bit
`define URX_TICK_MID 4'h7
`define URX_TICK_LAST 4'hF
`define URX_CHAR_BITS 10
`define URX_TOUT_CHARS 4
`define URX_TOUT_TICKS (`URX_TOUT_CHARS * `URX_CHAR_BITS * 16)

`endif

/* File: hdl/urx_top.v */
// Purpose: receive side of an asynchronous serial port with ring indicator, request-to-send
//          and receive DMA ready signalling
// Assumes: ref_clk 10 MHz; rcv_clk is a 16x baud clock well below a quarter of ref_clk
// Notes: fixed 8 data bits, no parity, one stop bit
//
// Summary of operation
// - modem status bit 6 shows the complement of the present ring indicator level on every read.
// - modem status bit 2 sets when ring indicator rises LOW to HIGH.
// - a qualifying ring edge raises the interrupt when modem interrupt is enabled.
// - request-to-send follows control bit 1; HIGH at reset, in loopback, or bit cleared.
// - the request-to-send pin never affects receive or transmit operation.
// - in FIFO mode, FIFO control bit 3 selects the receive DMA scheme.
// - without FIFOs only the single-transfer scheme, mode 0, is available.
// - mode 0: DMA controller makes one transfer between host bus cycles.
// - mode 1: back-to-back transfers are served until the receive FIFO empties.
// - mode 0: ready LOW while any character is held, HIGH when none remain.
// - mode 1: ready LOW at trigger level or time-out, HIGH once empty.
// - the serial input is sampled with a separate 16x baud receive clock.
// - interrupt is HIGH while enabled condition pends; cleared by servicing or reset.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "urx_map.vh"

module urx_top (
	input wire ref_clk,
	input wire rst_b,
	input wire [2:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire rcv_clk,
	input wire rx_serial,
	input wire ring_indicator_n,
	output reg request_to_send_n,
	output reg rx_dma_ready_n,
	output reg irq
);

localparam ST_IDLE = 2'b00;
localparam ST_START = 2'b01;
localparam ST_DATA = 2'b10;
localparam ST_STOP = 2'b11;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: three stages, a level changes once stages two and three agree

reg [2:0] rck_sync;
reg [2:0] rxd_sync;
reg [2:0] ring_sync;
reg rck_level;
reg rck_prev;
reg rxd_level;
reg ring_level;

always @(posedge ref_clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		rck_sync <= 3'h0;
		rxd_sync <= 3'h7;
		ring_sync <= 3'h7;
		rck_level <= 1'b0;
		rck_prev <= 1'b0;
		rxd_level <= 1'b1;
		ring_level <= 1'b1;
	end
	else
	begin
		rck_sync <= {rck_sync[1:0], rcv_clk};
		rxd_sync <= {rxd_sync[1:0], rx_serial};
		ring_sync <= {ring_sync[1:0], ring_indicator_n};
		if (rck_sync[1] == rck_sync[2])
			rck_level <= rck_sync[2];
		if (rxd_sync[1] == rxd_sync[2])
			rxd_level <= rxd_sync[2];
		if (ring_sync[1] == ring_sync[2])
			ring_level <= ring_sync[2];
		rck_prev <= rck_level;
	end
end

// one sampling tick per rising edge of the 16x receive clock
wire tick = rck_level & ~rck_prev;

////////////////////////////////////////////////////////////////////////////////
// control registers

reg [3:0] int_enable;
reg [7:0] fifo_control_reg;
reg [4:0] modem_control_reg;
reg fifo_flush;

wire wr_fcr = reg_wr && (reg_addr == `URX_ADDR_FIFO_CONTROL);
wire rd_data = reg_rd && (reg_addr == `URX_ADDR_RX_DATA);
wire rd_lsr = reg_rd && (reg_addr == `URX_ADDR_LINE_STATUS);
wire rd_msr = reg_rd && (reg_addr == `URX_ADDR_MODEM_STATUS);

wire fifo_enable_bit = fifo_control_reg[`URX_FCR_FIFO_EN_BIT];
wire dma_mode_select_bit = fifo_control_reg[`URX_FCR_DMA_SEL_BIT];
wire loopback = modem_control_reg[`URX_MCR_LOOP_BIT];
// mode 1 needs FIFOs; otherwise mode 0 regardless of the select bit
wire dma_mode1 = fifo_enable_bit & dma_mode_select_bit;

always @(posedge ref_clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		int_enable <= `URX_RST_INT_ENABLE;
		fifo_control_reg <= `URX_RST_FIFO_CONTROL;
		modem_control_reg <= `URX_RST_MODEM_CONTROL;
		fifo_flush <= 1'b0;
	end
	else
	begin
		fifo_flush <= 1'b0;
		if (reg_wr)
		begin
			if (reg_addr == `URX_ADDR_INT_ENABLE)
				int_enable <= reg_wdata[3:0];
			else if (reg_addr == `URX_ADDR_FIFO_CONTROL)
				fifo_control_reg <= {reg_wdata[7:6], 2'b00, reg_wdata[3], 2'b00, reg_wdata[0]};
			else if (reg_addr == `URX_ADDR_MODEM_CONTROL)
				modem_control_reg <= reg_wdata[4:0];
		end
		// flush on request or on any change of FIFO enable
		if (wr_fcr && (reg_wdata[`URX_FCR_RX_FLUSH_BIT] ||
			(reg_wdata[`URX_FCR_FIFO_EN_BIT] != fifo_enable_bit)))
			fifo_flush <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// ring indicator: level, edge flag and interrupt

reg ring_prev;
reg ring_edge_flag;

// in loopback the ring input is taken from control bit OUT1
wire ring_n_int = loopback ? ~modem_control_reg[`URX_MCR_OUT1_BIT] : ring_level;
wire ring_rise = ring_n_int & ~ring_prev;
wire msi_enable = int_enable[`URX_IER_MODEM_BIT];

always @(posedge ref_clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		ring_prev <= 1'b1;
		ring_edge_flag <= 1'b0;
		irq <= 1'b0;
	end
	else
	begin
		ring_prev <= ring_n_int;
		// a new edge in the read cycle survives the clear
		if (ring_rise)
			ring_edge_flag <= 1'b1;
		else if (rd_msr)
			ring_edge_flag <= 1'b0;
		irq <= msi_enable & (ring_rise | (ring_edge_flag & ~rd_msr));
	end
end

////////////////////////////////////////////////////////////////////////////////
// request-to-send: pure output, read by nothing inside the receiver

always @(posedge ref_clk or negedge rst_b)
begin
	if (!rst_b)
		request_to_send_n <= 1'b1;
	else
		request_to_send_n <= ~(modem_control_reg[`URX_MCR_RTS_BIT] & ~loopback);
end

////////////////////////////////////////////////////////////////////////////////
// serial receiver, 8N1, mid-bit sampling on the 16x tick

reg [1:0] rx_state;
reg [3:0] tick_cnt;
reg [2:0] bit_cnt;
reg [7:0] shift;
reg char_done;
reg char_frame_bad;

// the line idles high in loopback since no transmitter is present here
wire rxd_int = loopback ? 1'b1 : rxd_level;

always @(posedge ref_clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		rx_state <= ST_IDLE;
		tick_cnt <= 4'h0;
		bit_cnt <= 3'h0;
		shift <= 8'h00;
		char_done <= 1'b0;
		char_frame_bad <= 1'b0;
	end
	else
	begin
		char_done <= 1'b0;
		if (tick)
		begin
			tick_cnt <= tick_cnt + 4'h1;
			case (rx_state)
			ST_IDLE:
			begin
				tick_cnt <= 4'h0;
				if (!rxd_int)
					rx_state <= ST_START;
			end
			ST_START:
			begin
				if (tick_cnt == `URX_TICK_MID)
				begin
					tick_cnt <= 4'h0;
					bit_cnt <= 3'h0;
					rx_state <= rxd_int ? ST_IDLE : ST_DATA;
				end
			end
			ST_DATA:
			begin
				if (tick_cnt == `URX_TICK_LAST)
				begin
					shift <= {rxd_int, shift[7:1]};
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == 3'h7)
						rx_state <= ST_STOP;
				end
			end
			default:
			begin
				if (tick_cnt == `URX_TICK_LAST)
				begin
					char_done <= 1'b1;
					char_frame_bad <= ~rxd_int;
					rx_state <= ST_IDLE;
				end
			end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// receive FIFO; holding register behaviour when FIFOs are off

wire f_in_ready;
wire f_out_valid;
wire [7:0] f_out_data;
wire [5:0] f_count;
// one character of room without FIFOs, full depth with them
wire room = fifo_enable_bit ? f_in_ready : ~f_out_valid;
wire accept = char_done & room;

urx_fifo #(
	.WIDTH(`URX_FIFO_WIDTH),
	.DEPTH(`URX_FIFO_DEPTH),
	.AW(`URX_FIFO_AW)
) u_fifo (
	.ref_clk(ref_clk),
	.rst_b(rst_b),
	.flush(fifo_flush),
	.in_valid(accept),
	.in_ready(f_in_ready),
	.in_data(shift),
	.out_valid(f_out_valid),
	.out_ready(rd_data),
	.out_data(f_out_data),
	.count(f_count)
);

////////////////////////////////////////////////////////////////////////////////
// line status and character time-out

reg overrun;
reg framing;
reg [9:0] tout_cnt;
reg timed_out;

always @(posedge ref_clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		overrun <= 1'b0;
		framing <= 1'b0;
		tout_cnt <= 10'h000;
		timed_out <= 1'b0;
	end
	else
	begin
		if (char_done && !room)
			overrun <= 1'b1;
		else if (rd_lsr)
			overrun <= 1'b0;
		if (accept && char_frame_bad)
			framing <= 1'b1;
		else if (rd_lsr)
			framing <= 1'b0;
		// restarts on every push or pop, idle while empty
		if (accept || rd_data || !f_out_valid)
		begin
			tout_cnt <= 10'h000;
			timed_out <= 1'b0;
		end
		else if (tick && !timed_out)
		begin
			tout_cnt <= tout_cnt + 10'h001;
			if (tout_cnt == `URX_TOUT_TICKS - 1)
				timed_out <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// receive DMA ready

reg [5:0] trig_level;

always @*
begin
	case (fifo_control_reg[`URX_FCR_TRIG_HI:`URX_FCR_TRIG_LO])
	2'b00: trig_level = `URX_TRIG_LVL0;
	2'b01: trig_level = `URX_TRIG_LVL1;
	2'b10: trig_level = `URX_TRIG_LVL2;
	default: trig_level = `URX_TRIG_LVL3;
	endcase
end

reg next_rx_dma_ready_n;

always @*
begin
	next_rx_dma_ready_n = rx_dma_ready_n;
	if (!dma_mode1)
		next_rx_dma_ready_n = ~f_out_valid;
	else if (!f_out_valid)
		next_rx_dma_ready_n = 1'b1;
	else if ((f_count >= trig_level) || timed_out)
		next_rx_dma_ready_n = 1'b0;
end

always @(posedge ref_clk or negedge rst_b)
begin
	if (!rst_b)
		rx_dma_ready_n <= 1'b1;
	else
		rx_dma_ready_n <= next_rx_dma_ready_n;
end

////////////////////////////////////////////////////////////////////////////////
// register read path, data one cycle after the strobe

wire [7:0] modem_status_reg = {1'b0, ~ring_n_int, 3'b000, ring_edge_flag, 2'b00};
wire [7:0] line_status = {4'h0, framing, 1'b0, overrun, f_out_valid};

always @(posedge ref_clk or negedge rst_b)
begin
	if (!rst_b)
		reg_rdata <= 8'h00;
	else if (reg_rd)
	begin
		if (reg_addr == `URX_ADDR_RX_DATA)
			reg_rdata <= f_out_valid ? f_out_data : 8'h00;
		else if (reg_addr == `URX_ADDR_INT_ENABLE)
			reg_rdata <= {4'h0, int_enable};
		else if (reg_addr == `URX_ADDR_FIFO_CONTROL)
			reg_rdata <= fifo_control_reg;
		else if (reg_addr == `URX_ADDR_MODEM_CONTROL)
			reg_rdata <= {3'h0, modem_control_reg};
		else if (reg_addr == `URX_ADDR_LINE_STATUS)
			reg_rdata <= line_status;
		else if (reg_addr == `URX_ADDR_MODEM_STATUS)
			reg_rdata <= modem_status_reg;
		else
			reg_rdata <= 8'h00;
	end
	else
		reg_rdata <= 8'h00;
end

endmodule // urx_top

`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: self-checking bench for urx_top
// Assumes: 10 MHz ref_clk, seeded random data
// Notes: acts as host and dma controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk;
	logic rst_b;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	wire logic [7:0] reg_rdata;
	wire logic rcv_clk, rx_serial, ring_indicator_n, request_to_send_n, rx_dma_ready_n, irq;
	int bad_count;
	int comparisons;
	logic [7:0] v;
	logic [7:0] m;
	logic [7:0] q[$];
	// trigger codes that make mode 0 and mode 1 differ with one character held
	logic [7:0] fcr_set[5] = '{8'h00, 8'h48, 8'h41, 8'h89, 8'hC9};
	urx_top i_urx_top (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rcv_clk(rcv_clk), .rx_serial(rx_serial),
		.ring_indicator_n(ring_indicator_n), .request_to_send_n(request_to_send_n),
		.rx_dma_ready_n(rx_dma_ready_n), .irq(irq));
	urx_modem i_urx_modem (.rcv_clk(rcv_clk), .rx_serial(rx_serial), .ring_indicator_n(ring_indicator_n));
	////////////////////////////////////////////////////////////
	function automatic logic exp_rts(input logic [7:0] mc);
		return !(mc[1] && !mc[4]);
	endfunction
	function automatic logic exp_ready(input logic [7:0] f, input int held);
		int lvl[4] = '{1, 4, 8, 14};
		if (f[0] && f[3])
			return held < lvl[f[7:6]];
		return held == 0;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask
	task automatic rx_char(input logic [7:0] ch);
		q.push_back(ch);
		i_urx_modem.send(ch);
		idle(8);
	endtask
	task automatic pop_check;
		rd(3'h0, v);
		check(v, q.pop_front());
	endtask
	task automatic end_of_test;
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial
	begin
		#6_000_000;
		bad_count++;
		end_of_test;
	end
	initial
	begin
		rst_b = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		void'($urandom(32'hE6773340));
		idle(16);
		rst_b <= 1'b1;
		@(negedge ref_clk);
		check({7'h00, request_to_send_n}, 8'h01);
		check({7'h00, rx_dma_ready_n}, 8'h01);
		check({7'h00, irq}, 8'h00);
		rd(3'h6, v);
		check(v, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			m = (i < 4) ? {3'h0, i[0], 2'h0, ~i[1], 1'b0} : 8'($urandom) & 8'h16;
			wr(3'h4, m);
			idle(2);
			@(negedge ref_clk);
			check({7'h00, request_to_send_n}, {7'h00, exp_rts(m)});
		end
		wr(3'h4, 8'h02);
		rd(3'h6, v);
		wr(3'h1, 8'h08);
		i_urx_modem.ring(1'b0);
		idle(12);
		rd(3'h6, v);
		check(v & 8'h44, 8'h40);
		i_urx_modem.ring(1'b1);
		idle(12);
		check({7'h00, irq}, 8'h01);
		rd(3'h6, v);
		check(v & 8'h44, 8'h04);
		check({7'h00, irq}, 8'h00);
		rd(3'h6, v);
		check(v & 8'h44, 8'h00);
		wr(3'h1, 8'h00);
		i_urx_modem.ring(1'b0);
		idle(12);
		i_urx_modem.ring(1'b1);
		idle(12);
		check({7'h00, irq}, 8'h00);
		rd(3'h6, v);
		check(v & 8'h44, 8'h04);
		foreach (fcr_set[i])
		begin
			wr(3'h4, {6'h00, i[0], 1'b0});
			wr(3'h2, fcr_set[i]);
			rx_char((i == 0) ? 8'hFF : 8'($urandom));
			check({7'h00, rx_dma_ready_n}, {7'h00, exp_ready(fcr_set[i], 1)});
			pop_check;
			idle(3);
			check({7'h00, rx_dma_ready_n}, 8'h01);
		end
		wr(3'h2, 8'h49);
		for (int i = 0; i < 4; i++)
		begin
			rx_char((i == 0) ? 8'h00 : 8'($urandom));
			check({7'h00, rx_dma_ready_n}, {7'h00, exp_ready(8'h49, q.size())});
		end
		while (q.size() > 0)
		begin
			pop_check;
			if (q.size() > 0)
				check({7'h00, rx_dma_ready_n}, 8'h00);
		end
		idle(3);
		check({7'h00, rx_dma_ready_n}, 8'h01);
		rx_char(8'($urandom));
		check({7'h00, rx_dma_ready_n}, 8'h01);
		idle(7000);
		check({7'h00, rx_dma_ready_n}, 8'h00);
		pop_check;
		idle(3);
		check({7'h00, rx_dma_ready_n}, 8'h01);
		end_of_test;
	end
endmodule // tb_top
`default_nettype wire

/* File: sim/urx_checker.sv */
// Purpose: port assertions for urx_top
// Assumes: one clock, rst_b async active low
// Notes: bound to every urx_top
`timescale 1ns/1ps
`default_nettype none
module urx_checker (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic ring_indicator_n,
	input wire logic request_to_send_n,
	input wire logic rx_dma_ready_n,
	input wire logic irq
);
	logic ring_q;
	logic ier_on;
	logic [7:0] still;
	logic [3:0] hist;
	wire logic msr_rd = reg_rd && reg_addr == 3'h6 && still > 8'h08;
	wire logic mcr_wr = reg_wr && reg_addr == 3'h4;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	// quiet time of the ring pin, enable mirror, recent pops or fifo control writes
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ring_q <= 1'b1;
			still <= 8'h00;
			ier_on <= 1'b0;
			hist <= 4'h0;
		end
		else
		begin
			ring_q <= ring_indicator_n;
			still <= (ring_q != ring_indicator_n) ? 8'h00 : still + {7'h00, still != 8'hFF};
			if (reg_wr && reg_addr == 3'h1)
				ier_on <= reg_wdata[3];
			hist <= {hist[2:0], (reg_rd && reg_addr == 3'h0) || (reg_wr && reg_addr == 3'h2)};
		end
	end
	////////////////////////////////////////////////////////////
	// the control register lands at the write edge, the registered pin one edge later
	a_rts_write: assert property (mcr_wr |-> ##2
		request_to_send_n == !($past(reg_wdata[1], 2) && !$past(reg_wdata[4], 2)))
		else $error("rts level wrong after control write");
	a_rts_hold: assert property (!mcr_wr |=> ##1 $stable(request_to_send_n))
		else $error("rts moved without control write");
	a_ring_level: assert property (msr_rd |=> reg_rdata[6] == !$past(ring_indicator_n))
		else $error("ring level bit wrong");
	a_flag_clear: assert property (msr_rd ##2 msr_rd |=> !reg_rdata[2])
		else $error("ring edge flag survived a read");
	a_irq_clear: assert property (msr_rd |=> !irq)
		else $error("irq kept after status read");
	a_irq_masked: assert property (!ier_on ##1 !ier_on |-> !irq)
		else $error("irq while masked");
	a_irq_rise: assert property (ier_on && $rose(ring_indicator_n) |-> ##[1:8] irq)
		else $error("no irq after ring edge");
	a_ready_rise: assert property ($rose(rx_dma_ready_n) |-> hist != 4'h0)
		else $error("dma ready released with no pop");
endmodule // urx_checker
bind urx_top urx_checker i_urx_checker (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.ring_indicator_n(ring_indicator_n), .request_to_send_n(request_to_send_n),
	.rx_dma_ready_n(rx_dma_ready_n), .irq(irq));
`default_nettype wire

/* File: sim/urx_modem.sv */
// Purpose: modem side: receive clock, serial line, ring pin
// Assumes: line idles high
// Notes: receive clock runs free, 1 us period
`timescale 1ns/1ps
`default_nettype none
module urx_modem (
	output logic rcv_clk,
	output logic rx_serial,
	output logic ring_indicator_n
);
	initial
	begin
		rx_serial = 1'b1;
		ring_indicator_n = 1'b1;
		rcv_clk = 1'b0;
		forever #500 rcv_clk = ~rcv_clk;
	end
	// one 8N1 character, lsb first, 16 ticks a bit
	task automatic send(input logic [7:0] ch);
		logic [9:0] frame;
		frame = {1'b1, ch, 1'b0};
		for (int i = 0; i < 160; i++)
		begin
			@(posedge rcv_clk);
			rx_serial <= frame[i / 16];
		end
		@(posedge rcv_clk);
	endtask
	task automatic ring(input logic lvl);
		ring_indicator_n <= lvl;
	endtask
endmodule // urx_modem
`default_nettype wire
